//--- rtl/regbank.sv
// Indexed register bank with APB index/data ports, socket pins and interrupt
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module regbank
  import regbank_pkg::*;
#(
  parameter logic [7:0] CHIP_REV = 8'h5a,  // Arbitrary identification value
  parameter int         NUM_SOCK = MAX_SOCK,
  parameter logic       DEV_SEL  = 1'b0
) (
  // Clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            rstn,
  // Power-good pin
  input  wire logic                            power_good_input,
  // APB slave
  input  wire apb_req_t                        apb_req,
  output logic [31:0]                          prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Socket pins
  input  wire logic [MAX_SOCK-1:0][IN_W-1:0]   card_in,
  output logic [MAX_SOCK-1:0][OUT_W-1:0]       card_out,
  output logic [MAX_SOCK-1:0]                  func_active,
  output logic [MAX_SOCK-1:0]                  sleep_active,
  output logic [MAX_SOCK-1:0][LVL_W-1:0]       level_out,
  // Interrupt
  output logic                                 irq
);

  bank_st_t st_r;
  bank_st_t st_nxt;

  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic [7:0] wm);
    merge = (old & ~wm) | (wd & wm);
  endfunction : merge

  function automatic logic [7:0] sock_read(input sock_t s, input logic [5:0] r);
    logic [7:0] d;
    d = 8'h00;
    case (r)
      REG_PIN_IN:  d = FIXED_PIN_IN | {{(8-IN_W){1'b0}}, s.in_s2};
      REG_CTL:     d = s.ctl;
      REG_MODE:    d = s.mode | FIXED_MODE;
      REG_EVT:     d = {{(8-IN_W){1'b0}}, s.evt};
      REG_VALUE:   d = s.value;
      REG_SCRATCH: d = s.scratch;
      default:     d = 8'h00;
    endcase
    sock_read = d;
  endfunction : sock_read

  function automatic sock_t sock_reset(input sock_t s);
    sock_t t;
    t         = s;
    t.evt     = '0;
    t.ctl     = RST_CTL;
    t.mode    = RST_MODE;
    t.value   = RST_BYTE;
    t.scratch = RST_BYTE;
    sock_reset = t;
  endfunction : sock_reset

  // Chip-wide registers answer only at socket A's slot of this device
  function automatic logic chip_hit(input logic [7:0] idx, input logic [5:0] r);
    chip_hit = (idx[DEV_BIT] == DEV_SEL) && !idx[SOCK_BIT]
               && (idx[5:0] == r);
  endfunction : chip_hit

  // Socket registers of a fitted socket; chip-wide numbers are excluded
  function automatic logic sock_hit(input logic [7:0] idx);
    logic is_chip;
    is_chip  = (idx[5:0] == REG_CHIP_ID) || (idx[5:0] == REG_CHIP_CTL);
    sock_hit = (idx[DEV_BIT] == DEV_SEL) && !is_chip
               && (int'(idx[SOCK_BIT]) < NUM_SOCK);
  endfunction : sock_hit

  // One socket register write; positions outside the mask keep their value
  function automatic sock_t sock_write(input sock_t s, input logic [5:0] r,
                                       input logic [7:0] wd);
    sock_t t;
    t = s;
    case (r)
      REG_CTL:     t.ctl     = merge(s.ctl, wd, WM_CTL);
      REG_MODE:    t.mode    = merge(s.mode, wd, WM_MODE);
      REG_VALUE:   t.value   = merge(s.value, wd, WM_BYTE);
      REG_SCRATCH: t.scratch = merge(s.scratch, wd, WM_BYTE);
      REG_EVT:     t.evt     = s.evt & ~wd[IN_W-1:0];
      default:     t         = s;
    endcase
    sock_write = t;
  endfunction : sock_write

  // Index fields, access decode and read data
  logic [5:0]          reg_sel;
  logic                sock_sel;
  logic                access;
  logic                wr_done;
  logic [7:0]          data_rd;
  logic [EVT_W-1:0]    evt_all;
  logic [7:0]          wbyte;

  always_comb begin
    reg_sel  = st_r.index[5:0];
    sock_sel = st_r.index[SOCK_BIT];
    access   = apb_req.psel && apb_req.penable;
    wr_done  = access && st_r.pready && apb_req.pwrite;
    wbyte    = apb_req.pwdata[7:0];
    for (int s = 0; s < MAX_SOCK; s++) begin
      evt_all[s*IN_W +: IN_W] = st_r.sk[s].evt;
    end
    // Chip-wide registers exist only at socket A's index
    data_rd = 8'h00;
    if (chip_hit(st_r.index, REG_CHIP_ID)) begin
      data_rd = CHIP_REV;
    end else if (chip_hit(st_r.index, REG_CHIP_CTL)) begin
      data_rd = st_r.chip_ctl;
    end else if (sock_hit(st_r.index)) begin
      data_rd = sock_read(st_r.sk[sock_sel], reg_sel);
    end
  end

  always_comb begin
    st_nxt      = st_r;
    st_nxt.pg_s = {st_r.pg_s[0], power_good_input};

    // Pin sampling and event capture; a new event beats a same-cycle host clear
    for (int s = 0; s < MAX_SOCK; s++) begin
      st_nxt.sk[s].in_s1   = card_in[s];
      st_nxt.sk[s].in_s2   = st_r.sk[s].in_s1;
      st_nxt.sk[s].in_prev = st_r.sk[s].in_s2;
    end

    // APB answer: one wait cycle, then pready for one cycle
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (access && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata  = 32'h0000_0000;
      case (apb_req.paddr)
        OFF_INDEX:    st_nxt.prdata[7:0] = st_r.index;
        OFF_DATA:     st_nxt.prdata[7:0] = data_rd;
        OFF_IRQ_STAT: st_nxt.prdata[EVT_W-1:0] = evt_all;
        OFF_IRQ_MASK: st_nxt.prdata[EVT_W-1:0] = st_r.irq_mask;
        default:      st_nxt.pslverr = 1'b1;
      endcase
    end

    // Writes take effect on the completing edge
    if (wr_done) begin
      case (apb_req.paddr)
        OFF_INDEX: begin
          st_nxt.index = wbyte;
        end
        OFF_DATA: begin
          if (chip_hit(st_r.index, REG_CHIP_CTL)) begin
            st_nxt.chip_ctl = merge(st_r.chip_ctl, wbyte, WM_CHIP_CTL);
          end else if (sock_hit(st_r.index)) begin
            // Based on the next copy so the pin synchroniser keeps moving
            st_nxt.sk[sock_sel] = sock_write(st_nxt.sk[sock_sel], reg_sel, wbyte);
          end
        end
        OFF_IRQ_STAT: begin
          for (int s = 0; s < MAX_SOCK; s++) begin
            st_nxt.sk[s].evt = st_r.sk[s].evt & ~apb_req.pwdata[s*IN_W +: IN_W];
          end
        end
        OFF_IRQ_MASK: begin
          st_nxt.irq_mask = apb_req.pwdata[EVT_W-1:0];
        end
        default: begin
          st_nxt.index = st_r.index;
        end
      endcase
    end

    // Event set applied after host clears so it wins over them; power-good low still clears it
    for (int s = 0; s < MAX_SOCK; s++) begin
      st_nxt.sk[s].evt = st_nxt.sk[s].evt | (st_r.sk[s].in_s2 ^ st_r.sk[s].in_prev);
      if (s >= NUM_SOCK) begin
        st_nxt.sk[s].evt = '0;
      end
    end

    // Power-good low reloads register contents; pins keep sampling
    if (!st_r.pg_s[1]) begin
      st_nxt.index    = RST_BYTE;
      st_nxt.chip_ctl = RST_CHIP_CTL;
      st_nxt.irq_mask = '0;
      for (int s = 0; s < MAX_SOCK; s++) begin
        st_nxt.sk[s] = sock_reset(st_nxt.sk[s]);
      end
    end

    // Pin drives; chip enable gates both sockets, compat bit is unused
    for (int s = 0; s < MAX_SOCK; s++) begin
      st_nxt.sk[s].func_active  = st_nxt.sk[s].ctl[CTL_FUNC_EN]
                                  && st_nxt.chip_ctl[CHIP_PIN_EN];
      st_nxt.sk[s].sleep_active = !st_nxt.sk[s].ctl[CTL_SLEEP_DIS];
      st_nxt.sk[s].card_out     = st_nxt.sk[s].func_active
                                  ? st_nxt.sk[s].ctl[CTL_OUT_LSB +: OUT_W]
                                  : '0;
      st_nxt.sk[s].level        = st_nxt.sk[s].mode[MODE_SEL]
                                  ? st_nxt.sk[s].value[LVL_W +: LVL_W]
                                  : st_nxt.sk[s].value[0 +: LVL_W];
      if (s >= NUM_SOCK) begin
        st_nxt.sk[s].func_active  = 1'b0;
        st_nxt.sk[s].sleep_active = 1'b0;
        st_nxt.sk[s].card_out     = '0;
        st_nxt.sk[s].level        = '0;
      end
    end

    // Irq follows next status so it is high as soon as the bit is
    st_nxt.irq = 1'b0;
    for (int s = 0; s < MAX_SOCK; s++) begin
      if ((st_nxt.sk[s].evt & st_nxt.irq_mask[s*IN_W +: IN_W]) != '0) begin
        st_nxt.irq = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r          <= '0;
      st_r.chip_ctl <= RST_CHIP_CTL;
      for (int s = 0; s < MAX_SOCK; s++) begin
        st_r.sk[s].ctl          <= RST_CTL;
        st_r.sk[s].sleep_active <= 1'b0;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    prdata  = st_r.prdata;
    pready  = st_r.pready;
    pslverr = st_r.pslverr;
    irq     = st_r.irq;
    for (int s = 0; s < MAX_SOCK; s++) begin
      card_out[s]     = st_r.sk[s].card_out;
      func_active[s]  = st_r.sk[s].func_active;
      sleep_active[s] = st_r.sk[s].sleep_active;
      level_out[s]    = st_r.sk[s].level;
    end
  end

endmodule : regbank

`default_nettype wire

//--- shared/regbank_pkg.sv
// Constants, field layouts and carrier types for the indexed register bank
// Behaviour
// - Each socket register exists per socket; socket B sits at index plus 40h.
// - Chip-wide registers decode at one index and govern both sockets.
// - Compatibility bits are stored and readable but steer nothing.
// - Fixed bits are read-only constants that host writes never change.
// - Scratchpad bits are plain storage returning the last written value.
// - Enable bits turn their function on when one.
// - Disable bits turn their function on when zero.
// - Input bits read back the sampled pin level.
// - Output bits drive their stored value onto their pin while the function is enabled, else zero.
// - A mode bit changes how another register's value is interpreted.
// - Read/write bits load their reset value when power-good cycles.
// - Read-only bits other than input bits show their reset value after power-good cycles; input bits keep showing the sampled pin.
// - Index bits 5:0 pick register, bit 6 socket, bit 7 controller.
// - Host writes index port, then accesses the selected register via data port.
package regbank_pkg;

  localparam int ADDR_W   = 12;
  localparam int MAX_SOCK = 2;
  localparam int IN_W     = 2;
  localparam int OUT_W    = 2;
  localparam int LVL_W    = 4;
  localparam int EVT_W    = MAX_SOCK * IN_W;

  // APB byte offsets of the index and data ports and interrupt registers
  localparam logic [ADDR_W-1:0] OFF_INDEX    = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_DATA     = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h00c;

  // Index layout
  localparam int          SOCK_BIT    = 6;
  localparam int          DEV_BIT     = 7;
  localparam logic [7:0]  SOCK_STRIDE = 8'h40;

  // Register numbers within a socket's 64 slots
  localparam logic [5:0] REG_CHIP_ID  = 6'h00;
  localparam logic [5:0] REG_PIN_IN   = 6'h01;
  localparam logic [5:0] REG_CTL      = 6'h02;
  localparam logic [5:0] REG_MODE     = 6'h03;
  localparam logic [5:0] REG_EVT      = 6'h04;
  localparam logic [5:0] REG_VALUE    = 6'h05;
  localparam logic [5:0] REG_SCRATCH  = 6'h06;
  localparam logic [5:0] REG_CHIP_CTL = 6'h07;

  // Control, mode and chip control register fields
  localparam int CTL_FUNC_EN   = 0;
  localparam int CTL_SLEEP_DIS = 1;
  localparam int CTL_OUT_LSB   = 2;
  localparam int MODE_SEL      = 0;
  localparam int CHIP_PIN_EN   = 0;

  // Writable masks, fixed values and reset values
  localparam logic [7:0] WM_CTL       = 8'h3f;
  localparam logic [7:0] WM_MODE      = 8'h01;
  localparam logic [7:0] WM_BYTE      = 8'hff;
  localparam logic [7:0] WM_CHIP_CTL  = 8'h03;
  localparam logic [7:0] FIXED_MODE   = 8'h02;
  localparam logic [7:0] FIXED_PIN_IN = 8'h80;
  localparam logic [7:0] RST_CTL      = 8'h02;
  localparam logic [7:0] RST_MODE     = 8'h00;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_CHIP_CTL = 8'h01;

  typedef struct packed {
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]      pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [IN_W-1:0]  in_s1;
    logic [IN_W-1:0]  in_s2;
    logic [IN_W-1:0]  in_prev;
    logic [IN_W-1:0]  evt;
    logic [7:0]       ctl;
    logic [7:0]       mode;
    logic [7:0]       value;
    logic [7:0]       scratch;
    logic [OUT_W-1:0] card_out;
    logic             func_active;
    logic             sleep_active;
    logic [LVL_W-1:0] level;
  } sock_t;

  typedef struct packed {
    logic [1:0]                pg_s;
    sock_t [MAX_SOCK-1:0]      sk;
    logic [7:0]                index;
    logic [7:0]                chip_ctl;
    logic [EVT_W-1:0]          irq_mask;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      irq;
  } bank_st_t;

endpackage : regbank_pkg

//--- tb/regbank_asserts.sv
// Port-level checks of the register bank
`timescale 1ns/1ns
`default_nettype none
module regbank_asserts
  import regbank_pkg::*;
(
  // Clock, reset, power
  input wire logic                            clk_sys,
  input wire logic                            rstn,
  input wire logic                            power_good_input,
  // APB
  input wire apb_req_t                        apb_req,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  // Pins
  input wire logic [MAX_SOCK-1:0][IN_W-1:0]   card_in,
  input wire logic [MAX_SOCK-1:0][OUT_W-1:0]  card_out,
  input wire logic [MAX_SOCK-1:0]             func_active,
  input wire logic [MAX_SOCK-1:0]             sleep_active,
  input wire logic [MAX_SOCK-1:0][LVL_W-1:0]  level_out,
  input wire logic                            irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Pins may only move after a write or a power-good drop, sync delay allowed
  logic [3:0] pg_low_r;
  logic [1:0] wr_r;
  logic       cause;
  assign cause = (|wr_r) || (|pg_low_r);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pg_low_r <= 4'h0;
      wr_r     <= 2'h0;
    end else begin
      pg_low_r <= {pg_low_r[2:0], !power_good_input};
      wr_r     <= {wr_r[0], pready && apb_req.pwrite};
    end
  end
  property p_wait; apb_req.psel && apb_req.penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait state");
  property p_pulse; $rose(pready) |=> $fell(pready); endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_idle; !apb_req.psel |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("ready without request");
  property p_out; $changed(card_out) |-> cause; endproperty
  a_out: assert property (p_out) else $error("output pins moved on their own");
  property p_lvl; $changed(level_out) |-> cause; endproperty
  a_lvl: assert property (p_lvl) else $error("level moved on its own");
  property p_func; $changed(func_active) |-> cause; endproperty
  a_func: assert property (p_func) else $error("enable moved on its own");
  property p_sleep; $changed(sleep_active) |-> cause; endproperty
  a_sleep: assert property (p_sleep) else $error("disable moved on its own");
  c_wr: cover property (pready && apb_req.pwrite);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule : regbank_asserts
bind regbank regbank_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn),
  .power_good_input(power_good_input), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .card_in(card_in), .card_out(card_out), .func_active(func_active),
  .sleep_active(sleep_active), .level_out(level_out), .irq(irq));
`default_nettype wire

//--- tb/host_model.sv
// Host side model: APB master issuing index and data port cycles
`timescale 1ns/1ns
`default_nettype none
module host_model
  import regbank_pkg::*;
(
  // Clock
  input wire logic        clk_sys,
  // APB
  output var apb_req_t    req,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  initial req = '0;
  // Caller sits on a rising edge; two idle edges let pin updates land
  task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    // No cycle count assumed; only the bench watchdog ends a hung wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    req <= '0;
    repeat (2) @(posedge clk_sys);
  endtask : xfer
endmodule : host_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import regbank_pkg::*;
  localparam logic [7:0] REV = 8'h3c; // Arbitrary identification value
  typedef struct packed { logic [7:0] idx; logic [7:0] wd; logic [7:0] exp; } row_t;
  logic clk_sys, rstn, power_good_input, pready, pslverr, irq, errv;
  logic [31:0] prdata, rdv;
  apb_req_t apb_req;
  logic [MAX_SOCK-1:0][IN_W-1:0] card_in;
  logic [MAX_SOCK-1:0][OUT_W-1:0] card_out;
  logic [MAX_SOCK-1:0] func_active, sleep_active;
  logic [MAX_SOCK-1:0][LVL_W-1:0] level_out;
  int n_errors = 0;
  int checks = 0;
  row_t rows [11] = '{
    '{8'h02, 8'h3f, 8'h3f},  // Reserved bits written as read
    '{8'h42, 8'h0d, 8'h0d},
    '{8'h03, 8'h01, 8'h03},  // Fixed bit written 0 stays 1
    '{8'h06, 8'ha5, 8'ha5},
    '{8'h46, 8'h5a, 8'h5a},
    '{8'h05, 8'h3c, 8'h3c},
    '{8'h00, 8'h00, REV},
    '{8'h40, 8'h77, 8'h00},
    '{8'h07, 8'h03, 8'h03},
    '{8'h44, 8'h03, 8'h00},
    '{8'h86, 8'h99, 8'h00}};
  host_model hm (.clk_sys(clk_sys), .req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  regbank #(.CHIP_REV(REV)) uut (.clk_sys(clk_sys), .rstn(rstn),
    .power_good_input(power_good_input), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_in(card_in), .card_out(card_out), .func_active(func_active),
    .sleep_active(sleep_active), .level_out(level_out), .irq(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    hm.xfer(1'b1, a, d, rdv, errv);
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a);
    hm.xfer(1'b0, a, 32'h0, rdv, errv);
  endtask : rd
  task rsel(input logic [7:0] i);
    wr(OFF_INDEX, {24'h0, i});
    rd(OFF_DATA);
  endtask : rsel
  task regw(input logic [7:0] i, input logic [7:0] d);
    wr(OFF_INDEX, {24'h0, i});
    wr(OFF_DATA, {24'h0, d});
  endtask : regw
  task report_and_stop;
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    power_good_input = 1'b1;
    card_in = '0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rsel({2'b00, REG_CTL});
    chk(rdv, 32'h02);
    rsel({2'b00, REG_MODE});
    chk(rdv, 32'h02);
    chk(sleep_active, 32'h0);
    foreach (rows[k]) begin
      regw(rows[k].idx, rows[k].wd);
      rsel(rows[k].idx);
      chk(rdv, {24'h0, rows[k].exp});
    end
    chk(card_out, 32'hf);
    chk(func_active, 32'h3);
    chk(sleep_active, 32'h2);
    chk(level_out, 32'h03);
    regw({2'b00, REG_MODE}, 8'h00);
    chk(level_out, 32'h0c);
    regw({2'b00, REG_CTL}, 8'h2f);
    chk({card_out, sleep_active}, 32'h3e);
    regw({2'b00, REG_CHIP_CTL}, 8'h02);
    chk(func_active, 32'h0);
    card_in <= {2'b00, 2'b01};
    repeat (5) @(posedge clk_sys);
    rsel({2'b00, REG_PIN_IN});
    chk(rdv, 32'h81);
    chk(irq, 32'h0);
    wr(OFF_IRQ_MASK, 32'h3);
    chk(irq, 32'h1);
    rd(OFF_IRQ_STAT);
    chk(rdv, 32'h1);
    wr(OFF_IRQ_STAT, 32'h1);
    chk(irq, 32'h0);
    rd(12'h010);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
    power_good_input <= 1'b0;
    repeat (4) @(posedge clk_sys);
    power_good_input <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rsel({2'b00, REG_SCRATCH});
    chk(rdv, 32'h0);
    rsel({2'b00, REG_MODE});
    chk(rdv, 32'h02);
    chk(sleep_active, 32'h0);
    regw({2'b00, REG_SCRATCH}, 8'h33);
    rsel({2'b00, REG_SCRATCH});
    chk(rdv, 32'h33);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rsel({2'b00, REG_SCRATCH});
    chk(rdv, 32'h0);
    rsel({2'b00, REG_CTL});
    chk(rdv, 32'h02);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
